// ---- verilog/fault_status_registers.v ----
// Purpose: Channel fault summary, fault type summary and global fault flag registers.
// Assumes: A serial front end decodes frames and gives a register select and read strobe.
// Notes: Fault detector levels arrive asynchronously and are synchronised here.
//
// Summary of operation
// (RQ1) Bits 3..0 of the channel summary show whether each channel has any of six faults.
// (RQ2) Global bit 6 shows a power-on reset and comes up as 1.
// (RQ3) The power-on bit clears on a global read and stays 0 until the next reset.
// (RQ4) Global bit 5 latches the die overtemperature warning and clears on read once gone.
// (RQ5) Global bit 4 latches serial link errors and clears on read once gone.
// (RQ6) Global bit 3 latches an access timeout and clears on read once gone.
// (RQ7) Global bit 2 latches logic supply lockout, resets to 1, clears on read once gone.
// (RQ8) Global bit 1 latches load supply warning, resets to 1, clears on read once gone.
// (RQ9) Global bit 0 latches load supply low, resets to 1, clears on read once gone.
// (RQ10) Type summary bit 0 is set while a link, timeout, warning or overtemp flag is set.
// (RQ11) Detectors are sampled each clock and a cause in a clearing cycle keeps the flag set.
// (RQ12) The host reads the global register after power-up and whenever the summary says so.
`timescale 1ns/10ps
`include "fault_status_map.vh"
module fault_status_registers
#(
  parameter CHANNELS = 4
)
(
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire [CHANNELS-1:0] reverse_current_fault_i,
  input wire [CHANNELS-1:0] channel_overtemp_fault_i,
  input wire [CHANNELS-1:0] overcurrent_fault_i,
  input wire [CHANNELS-1:0] open_load_on_fault_i,
  input wire [CHANNELS-1:0] open_load_off_fault_i,
  input wire [CHANNELS-1:0] short_to_supply_fault_i,
  input wire die_overtemp_i,
  input wire link_error_i,
  input wire access_timeout_i,
  input wire logic_supply_low_i,
  input wire load_supply_warn_i,
  input wire load_supply_low_i,
  input wire [7:0] reg_addr_i,
  input wire reg_read_i,
  output reg [7:0] read_data_o,
  output reg [7:0] channel_fault_summary_o,
  output reg [7:0] global_fault_flags_o,
  output reg global_summary_flag_o
);
  localparam NDET = 6 * CHANNELS + 6;

  wire [NDET-1:0] raw_det;
  wire [NDET-1:0] sync_det;
  wire [CHANNELS-1:0] any_fault;
  wire [5:0] cause;
  wire [5:0] flag;
  wire [7:0] global_now;
  wire [7:0] type_now;
  wire [7:0] channel_now;
  wire global_read;
  reg [7:0] next_read_data;
  reg power_on_flag;
  genvar g;

  function sel;
    input [7:0] addr;
    input [7:0] offset;
    begin
      sel = (addr == offset);
    end
  endfunction

  assign raw_det = {load_supply_low_i, load_supply_warn_i, logic_supply_low_i,
                    access_timeout_i, link_error_i, die_overtemp_i,
                    short_to_supply_fault_i, open_load_off_fault_i, open_load_on_fault_i,
                    overcurrent_fault_i, channel_overtemp_fault_i, reverse_current_fault_i};

  level_sync #(.WIDTH(NDET)) u_sync
  (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(raw_det),
    .sync_o(sync_det)
  ); // [RQ11]

  generate
    for (g = 0; g < CHANNELS; g = g + 1)
    begin : chan
      // The channel summary follows the live condition, as do type summary bits 6..1; no channel fault is latched.
      assign any_fault[g] = sync_det[g] | sync_det[CHANNELS + g] | sync_det[2*CHANNELS + g]
                          | sync_det[3*CHANNELS + g] | sync_det[4*CHANNELS + g]
                          | sync_det[5*CHANNELS + g]; // [RQ1]
    end
  endgenerate

  // Order of cause: die overtemp, link, timeout, logic low, load warn, load low.
  assign cause = sync_det[NDET-1:NDET-6];
  assign global_read = reg_read_i & sel(reg_addr_i, `FS_OFF_GLOBAL_FLAGS);

  sticky_flag #(.RESET_VALUE(1'b0)) u_overtemp
  (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .cause_i(cause[0]), .clear_i(global_read), .flag_o(flag[0])
  ); // [RQ4]
  sticky_flag #(.RESET_VALUE(1'b0)) u_link
  (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .cause_i(cause[1]), .clear_i(global_read), .flag_o(flag[1])
  ); // [RQ5]
  sticky_flag #(.RESET_VALUE(1'b0)) u_timeout
  (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .cause_i(cause[2]), .clear_i(global_read), .flag_o(flag[2])
  ); // [RQ6]
  sticky_flag #(.RESET_VALUE(1'b1)) u_logic_low
  (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .cause_i(cause[3]), .clear_i(global_read), .flag_o(flag[3])
  ); // [RQ7]
  sticky_flag #(.RESET_VALUE(1'b1)) u_load_warn
  (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .cause_i(cause[4]), .clear_i(global_read), .flag_o(flag[4])
  ); // [RQ8]
  sticky_flag #(.RESET_VALUE(1'b1)) u_load_low
  (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .cause_i(cause[5]), .clear_i(global_read), .flag_o(flag[5])
  ); // [RQ9]

  // Only the reset itself sets this bit, so any global read clears it.
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      power_on_flag <= 1'b1; // [RQ2]
    else if (global_read)
      power_on_flag <= 1'b0; // [RQ3]
  end

  assign global_now = {1'b0, power_on_flag, flag[0], flag[1], flag[2],
                       flag[3], flag[4], flag[5]};
  assign channel_now = {{(8-CHANNELS){1'b0}}, any_fault}; // [RQ1]
  assign type_now = {flag[3] | flag[5],
                     |sync_det[CHANNELS-1:0],
                     |sync_det[2*CHANNELS-1:CHANNELS],
                     |sync_det[3*CHANNELS-1:2*CHANNELS],
                     |sync_det[4*CHANNELS-1:3*CHANNELS],
                     |sync_det[5*CHANNELS-1:4*CHANNELS],
                     |sync_det[6*CHANNELS-1:5*CHANNELS],
                     flag[0] | flag[1] | flag[2] | flag[4]}; // [RQ10]

  always @*
  begin
    next_read_data = read_data_o;
    if (reg_read_i)
    begin
      if (sel(reg_addr_i, `FS_OFF_TYPE_SUMMARY))
        next_read_data = type_now;
      else if (sel(reg_addr_i, `FS_OFF_CHANNEL_SUMMARY))
        next_read_data = channel_now;
      else if (sel(reg_addr_i, `FS_OFF_GLOBAL_FLAGS))
        next_read_data = global_now;
      else
        next_read_data = 8'h00;
    end
  end

  // The read returns the value before the clear, so the host sees what it is clearing.
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      read_data_o <= 8'h00;
      channel_fault_summary_o <= `FS_CHANNEL_RESET;
      global_fault_flags_o <= `FS_GLOBAL_RESET;
      // The load warning flag resets to 1, so the summary it feeds must reset set as well.
      global_summary_flag_o <= 1'b1; // [RQ10]
    end
    else
    begin
      read_data_o <= next_read_data;
      channel_fault_summary_o <= channel_now;
      global_fault_flags_o <= global_now;
      global_summary_flag_o <= type_now[`FS_BIT_GLOBAL_SUMMARY]; // [RQ10]
    end
  end
endmodule

// ---- verilog/fault_status_map.vh ----
// Purpose: Offsets, field positions, reset values and timing counts of the fault status registers.
// Assumes: Eight-bit registers reached through a register select and a read strobe.
// Notes: Definitions only.
`ifndef FAULT_STATUS_MAP_VH
`define FAULT_STATUS_MAP_VH
`define FS_OFF_TYPE_SUMMARY 8'h00
`define FS_OFF_CHANNEL_SUMMARY 8'h01
`define FS_OFF_GLOBAL_FLAGS 8'h02
`define FS_GLOBAL_RESET 8'h47
`define FS_CHANNEL_RESET 8'h00
`define FS_BIT_POWER_ON 6
`define FS_BIT_DIE_OVERTEMP 5
`define FS_BIT_LINK_ERROR 4
`define FS_BIT_ACCESS_TIMEOUT 3
`define FS_BIT_LOGIC_SUPPLY_LOW 2
`define FS_BIT_LOAD_SUPPLY_WARN 1
`define FS_BIT_LOAD_SUPPLY_LOW 0
`define FS_BIT_SUPPLY_SUMMARY 7
`define FS_BIT_GLOBAL_SUMMARY 0
`define FS_SYNC_STAGES 2
`endif

// ---- verilog/level_sync.v ----
// Purpose: Two-stage synchroniser for a bus of asynchronous fault levels.
// Assumes: Inputs come from analogue detectors outside the clock domain.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
module level_sync
#(
  parameter WIDTH = 1
)
(
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta;

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end
    else
    begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule

// ---- verilog/sticky_flag.v ----
// Purpose: One latched fault flag that clears on a read once its cause is gone.
// Assumes: Cause and read strobe are both on the core clock.
// Notes: A cause present in the clearing cycle keeps the flag set.
`timescale 1ns/10ps
module sticky_flag
#(
  parameter RESET_VALUE = 1'b0
)
(
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire cause_i,
  input wire clear_i,
  output reg flag_o
);
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      flag_o <= RESET_VALUE;
    else if (cause_i)
      flag_o <= 1'b1; // [RQ11]
    else if (clear_i)
      flag_o <= 1'b0;
  end
endmodule

// ---- tb/fault_status_chk.sv ----
// Purpose: Port assertions for the fault status registers.
// Assumes: Fault inputs are low while reset is held.
// Notes: Flag mirrors lag the internal flags by one edge.
`timescale 1ns/10ps
module fault_status_chk
#(
  parameter CHANNELS = 4
)
(
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire [CHANNELS-1:0] reverse_current_fault_i,
  input wire [CHANNELS-1:0] channel_overtemp_fault_i,
  input wire [CHANNELS-1:0] overcurrent_fault_i,
  input wire [CHANNELS-1:0] open_load_on_fault_i,
  input wire [CHANNELS-1:0] open_load_off_fault_i,
  input wire [CHANNELS-1:0] short_to_supply_fault_i,
  input wire die_overtemp_i,
  input wire link_error_i,
  input wire access_timeout_i,
  input wire logic_supply_low_i,
  input wire load_supply_warn_i,
  input wire load_supply_low_i,
  input wire [7:0] reg_addr_i,
  input wire reg_read_i,
  input wire [7:0] read_data_o,
  input wire [7:0] channel_fault_summary_o,
  input wire [7:0] global_fault_flags_o,
  input wire global_summary_flag_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire glob_rd = reg_read_i && reg_addr_i == 8'h02;
  wire [CHANNELS-1:0] any_flt = reverse_current_fault_i | channel_overtemp_fault_i
    | overcurrent_fault_i | open_load_on_fault_i | open_load_off_fault_i
    | short_to_supply_fault_i;
  property p_chan_top; channel_fault_summary_o[7:4] == 4'h0; endproperty
  a_chan_top: assert property (p_chan_top) else $error("channel summary top bits set");
  property p_chan_or;
    $past(rst_n_i, 3) |-> channel_fault_summary_o[CHANNELS-1:0] == $past(any_flt, 3);
  endproperty
  a_chan_or: assert property (p_chan_or) else $error("channel summary wrong");
  property p_por_clear; glob_rd |-> ##2 !global_fault_flags_o[6]; endproperty
  a_por_clear: assert property (p_por_clear) else $error("power-on flag kept");
  property p_por_stay; !global_fault_flags_o[6] |=> !global_fault_flags_o[6]; endproperty
  a_por_stay: assert property (p_por_stay) else $error("power-on flag came back");
  property p_read_glob; glob_rd |=> read_data_o == global_fault_flags_o; endproperty
  a_read_glob: assert property (p_read_glob) else $error("global read data wrong");
  property p_fall;
    |($past(global_fault_flags_o[5:0]) & ~global_fault_flags_o[5:0]) |-> $past(glob_rd, 2);
  endproperty
  a_fall: assert property (p_fall) else $error("flag cleared without read");
  property p_die; die_overtemp_i && $past(die_overtemp_i) |-> ##3 global_fault_flags_o[5];
  endproperty
  a_die: assert property (p_die) else $error("overtemp flag not set");
  property p_link; link_error_i && $past(link_error_i) |-> ##3 global_fault_flags_o[4];
  endproperty
  a_link: assert property (p_link) else $error("link flag lost");
  property p_sum; global_summary_flag_o == |(global_fault_flags_o & 8'h3a); endproperty
  a_sum: assert property (p_sum) else $error("summary flag wrong");
endmodule
bind fault_status_registers fault_status_chk #(.CHANNELS(CHANNELS)) chk_u (.*);

// ---- tb/status_host.sv ----
// Purpose: Host side that reads the status registers.
// Assumes: One strobe per access, launched on a falling edge.
// Notes: Read data holds until the next strobe.
`timescale 1ns/10ps
module status_host
(
  input wire sys_clk_i,
  input wire [7:0] read_data_i,
  output logic [7:0] reg_addr_o,
  output logic reg_read_o
);
  initial
  begin
    reg_addr_o = 8'h00;
    reg_read_o = 1'b0;
  end
  // A released address is inverted so that a stale value is never mistaken for a request.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_read_o = 1'b1;
    @(negedge sys_clk_i);
    reg_read_o = 1'b0;
    reg_addr_o = ~a;
    d = read_data_i;
  endtask
endmodule

// ---- tb/test_fault_status_registers.sv ----
// Purpose: Self-checking bench for the fault status registers.
// Assumes: Causes are held long enough to pass the synchronisers.
// Notes: The flag model is set at settle points and, except for bits whose cause is still held, cleared after each global read.
`timescale 1ns/10ps
module test_fault_status_registers;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] cause = 6'h00;
  logic [3:0] rev = 4'h0, ot = 4'h0, oc = 4'h0, lon = 4'h0, lof = 4'h0, sh = 4'h0;
  logic [7:0] addr, rdata, chan_o, glob_o;
  logic rd, gsum;
  logic [7:0] m_glob = 8'h47;
  logic [31:0] seed = 32'ha296;
  int bad_count = 0, checks_done = 0, cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  fault_status_registers dut_u (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
    .reverse_current_fault_i(rev), .channel_overtemp_fault_i(ot), .overcurrent_fault_i(oc),
    .open_load_on_fault_i(lon), .open_load_off_fault_i(lof), .short_to_supply_fault_i(sh),
    .die_overtemp_i(cause[5]), .link_error_i(cause[4]), .access_timeout_i(cause[3]),
    .logic_supply_low_i(cause[2]), .load_supply_warn_i(cause[1]),
    .load_supply_low_i(cause[0]), .reg_addr_i(addr), .reg_read_i(rd), .read_data_o(rdata),
    .channel_fault_summary_o(chan_o), .global_fault_flags_o(glob_o),
    .global_summary_flag_o(gsum));
  status_host host_u (.sys_clk_i(sys_clk), .read_data_i(rdata), .reg_addr_o(addr),
    .reg_read_o(rd));
  task automatic give_verdict;
    if (bad_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    chk("read_data", e, d);
  endtask
  task automatic rdg;
    rdc(8'h02, m_glob);
    m_glob = m_glob & {2'b00, cause};
  endtask
  task automatic settle;
    repeat (5) @(negedge sys_clk);
    m_glob = m_glob | {2'b00, cause};
  endtask
  function automatic logic [7:0] type_exp();
    return {m_glob[2] | m_glob[0], |rev, |ot, |oc, |lon, |lof, |sh, |(m_glob & 8'h3a)};
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    settle();
    chk("global_flags", 8'h47, glob_o);
    rdg();
    rdg();
    rdc(8'h07, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      cause[i] = 1'b1;
      settle();
      chk("summary_flag", {7'h00, |(m_glob & 8'h3a)}, {7'h00, gsum});
      rdc(8'h00, type_exp());
      rdg();
      cause[i] = 1'b0;
      settle();
      rdg();
      rdg();
    end
    for (int j = 0; j < 8; j++)
    begin
      seed = lfsr(seed);
      {rev, ot, oc, lon, lof, sh} = seed[23:0];
      settle();
      chk("channel_summary", {4'h0, rev | ot | oc | lon | lof | sh}, chan_o);
      rdc(8'h01, {4'h0, rev | ot | oc | lon | lof | sh});
      rdc(8'h00, type_exp());
    end
    give_verdict();
  end
endmodule
